// ===== hdl/csc_config_logic.sv
`timescale 1ns/10ps
// Operation
// - Default mode uses the first gain register's upper field for every input.
// - Writing 100 to misc mode bits 2:0 selects per-input gain fields.
// - Per-input gain mode asks the front end for a longer sensing period.
// - Every input is a button, a slider member or disabled.
// - Disabled inputs go anywhere; a button inside the slider span raises config error; proximity needs proximity enable.
// - Slider minimum maps to the lowest-indexed slider input.
// - Slider maximum maps to the highest-indexed slider input.
// - Eight gain levels; higher level scales ticks up proportionally.
// - Maximum ticks are 1000 or 4000 times level plus one.
// - Each input has its own threshold deciding touch and release.
// - Periodic recalibration fires at its interval if all is released, else at the first moment all is released after it.
// - Gain fields hold 0 to 7, reset 0; higher codes are reserved (stored as written, applied as 7).
// - Interval code 0 is off, 1-7 seconds, longer steps to 60 seconds.
module csc_config_logic #(
	parameter int unsigned RECAL_UNIT_CYCLES = csc_pkg::RECAL_UNIT_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire csc_pkg::csc_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire csc_pkg::csc_sample_t sample,
	output logic scaled_valid,
	output logic [csc_pkg::TICK_W-1:0] scaled_tick,
	output logic [csc_pkg::TICK_W-1:0] max_tick,
	output logic [csc_pkg::NUM_INPUTS-1:0] touch_status,
	output logic long_sense_period,
	output logic slider_present,
	output logic [csc_pkg::IDX_W-1:0] slider_min_index,
	output logic [csc_pkg::IDX_W-1:0] slider_max_index,
	output logic config_error,
	output logic recal_pulse
);

	localparam int unsigned N = csc_pkg::NUM_INPUTS;
	localparam int unsigned DIV_W = $clog2(RECAL_UNIT_CYCLES);

	if (RECAL_UNIT_CYCLES < 2) begin : g_check
		$error("csc_config_logic: RECAL_UNIT_CYCLES must be at least 2");
	end

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic [2:0] level_of(input logic [47:0] gain, input logic indiv,
		input logic [3:0] idx);
		logic [3:0] field;
		field = gain[7:4];
		if (indiv) begin
			field = gain[{idx[3:1], 3'h0} + (idx[0] ? 6'h0 : 6'h4) +: 4];
		end
		return (field > csc_pkg::GAIN_MAX) ? csc_pkg::GAIN_MAX[2:0] : field[2:0];
	endfunction

	function automatic logic [5:0] recal_seconds(input logic [3:0] code);
		if (code == csc_pkg::RECAL_CODE_MAX) begin
			return csc_pkg::RECAL_MAX_S;
		end else if (code[3]) begin
			return csc_pkg::RECAL_LONG_BASE_S + {2'h0, code[2:0], 1'b0};
		end
		return {2'h0, code};
	endfunction

	function automatic logic [3:0] count_ones(input logic [N-1:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < N; i++) begin
			c = c + {3'h0, v[i]};
		end
		return c;
	endfunction

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [2:0] misc_q;
	logic [23:0] role_q;
	logic [47:0] gain_q;
	logic [3:0] recal_code_q;
	logic [7:0] prox_q;
	logic indiv_mode;
	logic prox_on;
	logic [3:0] gain_idx;
	logic thr_wr;

	assign indiv_mode = (misc_q == csc_pkg::MODE_INDIVIDUAL);
	assign prox_on = (prox_q == csc_pkg::PROX_ON);
	assign gain_idx = 4'(bus_req.addr - csc_pkg::ADDR_GAIN_FIRST);
	assign thr_wr = bus_req.wr && (bus_req.addr >= csc_pkg::ADDR_THR_FIRST)
		&& (bus_req.addr <= csc_pkg::ADDR_THR_LAST);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			misc_q <= csc_pkg::MISC_RST;
			role_q <= {csc_pkg::ROLE_RST_8_11, csc_pkg::ROLE_RST_4_7, csc_pkg::ROLE_RST_0_3};
			gain_q <= {6{csc_pkg::GAIN_RST}};
			recal_code_q <= csc_pkg::RECAL_RST;
			prox_q <= csc_pkg::PROX_RST;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				csc_pkg::ADDR_MISC_MODE: misc_q <= bus_req.wdata[2:0];
				csc_pkg::ADDR_ROLE_8_11: role_q[23:16] <= bus_req.wdata;
				csc_pkg::ADDR_ROLE_4_7: role_q[15:8] <= bus_req.wdata;
				csc_pkg::ADDR_ROLE_0_3: role_q[7:0] <= bus_req.wdata;
				csc_pkg::ADDR_RECAL: recal_code_q <= bus_req.wdata[3:0];
				csc_pkg::ADDR_PROX: prox_q <= bus_req.wdata;
				default: begin
					if (bus_req.addr >= csc_pkg::ADDR_GAIN_FIRST
						&& bus_req.addr <= csc_pkg::ADDR_GAIN_LAST) begin
						gain_q[{gain_idx[2:0], 3'h0} +: 8] <= bus_req.wdata;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Role decode and slider placement
	// ---------------------------------------------------------------
	logic [N-1:0] button_mask;
	logic [N-1:0] slider_mask;
	logic [N-1:0] active_mask;
	logic [N-1:0] span_mask;
	logic [3:0] min_d;
	logic [3:0] max_d;
	logic [N-1:0] slider_mask_q;
	logic cfg_err_d;
	logic [3:0] slider_cnt;

	for (genvar g = 0; g < N; g++) begin : g_role
		assign button_mask[g] = (role_q[2*g +: 2] == csc_pkg::CSC_ROLE_BUTTON);
		assign slider_mask[g] = (role_q[2*g +: 2] == csc_pkg::CSC_ROLE_SLIDER);
		assign active_mask[g] = button_mask[g] | slider_mask[g];
		assign span_mask[g] = (4'(g) >= min_d) && (4'(g) <= max_d);
	end

	always_comb begin
		min_d = 4'h0;
		max_d = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (slider_mask[i]) begin
				min_d = 4'(i);
			end
		end
		for (int i = 0; i < N; i++) begin
			if (slider_mask[i]) begin
				max_d = 4'(i);
			end
		end
	end

	assign slider_cnt = count_ones(slider_mask);
	assign cfg_err_d = (count_ones(button_mask) > csc_pkg::MAX_BUTTONS)
		|| ((slider_cnt != 4'h0) && (slider_cnt < csc_pkg::MIN_SLIDER))
		|| ((slider_cnt != 4'h0) && |(button_mask & span_mask));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			slider_mask_q <= '0;
			slider_present <= 1'b0;
			slider_min_index <= '0;
			slider_max_index <= '0;
			config_error <= 1'b0;
			long_sense_period <= 1'b0;
		end else begin
			slider_mask_q <= slider_mask;
			slider_present <= |slider_mask;
			slider_min_index <= min_d;
			slider_max_index <= max_d;
			config_error <= cfg_err_d;
			long_sense_period <= indiv_mode;
		end
	end

	// ---------------------------------------------------------------
	// Tick scaling and touch decision
	// ---------------------------------------------------------------
	logic [2:0] lvl;
	logic [3:0] lvl1;
	logic [15:0] prod;
	logic [15:0] scaled_d;
	logic [15:0] max_d_tick;
	logic [3:0] idx_q;
	logic [7:0] thr_b;
	logic [7:0] thr_a;
	logic decide;
	logic idx_ok_q;

	assign lvl = level_of(gain_q, indiv_mode, sample.index);
	assign lvl1 = {1'b0, lvl} + 4'h1;
	assign prod = 16'({6'h0, sample.raw} * {12'h0, lvl1});
	assign max_d_tick = 16'((prox_on ? csc_pkg::TICK_STEP_ON : csc_pkg::TICK_STEP_OFF)
		* {12'h0, lvl1});
	always_comb begin
		scaled_d = prox_on ? {prod[13:0], 2'b00} : prod;
		if (scaled_d > max_d_tick) begin
			scaled_d = max_d_tick;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			scaled_valid <= 1'b0;
			scaled_tick <= '0;
			max_tick <= '0;
			idx_q <= '0;
			idx_ok_q <= 1'b0;
		end else begin
			scaled_valid <= sample.valid;
			idx_ok_q <= 32'(sample.index) < N;
			if (sample.valid) begin
				scaled_tick <= scaled_d;
				max_tick <= max_d_tick;
				idx_q <= sample.index;
			end
		end
	end

	csc_thresh_mem #(
		.DEPTH(N),
		.WIDTH(8),
		.RST_VALUE(csc_pkg::THR_RST)
	) u_thr (
		.mclk(mclk),
		.reset_n(reset_n),
		.wr_en(thr_wr),
		.wr_addr(4'(bus_req.addr - csc_pkg::ADDR_THR_FIRST)),
		.wr_data(bus_req.wdata),
		.rd_addr_a(4'(bus_req.addr - csc_pkg::ADDR_THR_FIRST)),
		.rd_data_a(thr_a),
		.rd_addr_b(sample.index),
		.rd_data_b(thr_b)
	);

	assign decide = active_mask[idx_q] && (scaled_tick > {6'h0, thr_b, 2'b00});

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			touch_status <= '0;
		end else begin
			if (scaled_valid && idx_ok_q) begin
				touch_status[idx_q] <= decide;
			end
			touch_status <= touch_status & active_mask;
			if (scaled_valid && idx_ok_q) begin
				touch_status[idx_q] <= decide;
			end
		end
	end

	// ---------------------------------------------------------------
	// Periodic recalibration
	// ---------------------------------------------------------------
	csc_pkg::csc_recal_state_t rc_q;
	logic [DIV_W-1:0] div_q;
	logic unit_tick;
	logic [5:0] elapsed_q;
	logic [5:0] interval_s;
	logic all_released;

	assign interval_s = recal_seconds(recal_code_q);
	assign all_released = ~|(touch_status & active_mask);
	assign unit_tick = (div_q == DIV_W'(RECAL_UNIT_CYCLES - 1));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
		end else if (unit_tick || rc_q != csc_pkg::CSC_RC_COUNT) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rc_q <= csc_pkg::CSC_RC_OFF;
			elapsed_q <= '0;
			recal_pulse <= 1'b0;
		end else begin
			recal_pulse <= 1'b0;
			case (rc_q)
				csc_pkg::CSC_RC_OFF: begin
					elapsed_q <= '0;
					if (interval_s != 6'h0) begin
						rc_q <= csc_pkg::CSC_RC_COUNT;
					end
				end
				csc_pkg::CSC_RC_COUNT: begin
					if (interval_s == 6'h0) begin
						rc_q <= csc_pkg::CSC_RC_OFF;
					end else if (unit_tick) begin
						elapsed_q <= elapsed_q + 6'h1;
						if (elapsed_q + 6'h1 >= interval_s) begin
							elapsed_q <= '0;
							if (all_released) begin
								recal_pulse <= 1'b1;
							end else begin
								rc_q <= csc_pkg::CSC_RC_WAIT;
							end
						end
					end
				end
				csc_pkg::CSC_RC_WAIT: begin
					if (interval_s == 6'h0) begin
						rc_q <= csc_pkg::CSC_RC_OFF;
					end else if (all_released) begin
						recal_pulse <= 1'b1;
						rc_q <= csc_pkg::CSC_RC_COUNT;
					end
				end
				default: rc_q <= csc_pkg::CSC_RC_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register read port
	// ---------------------------------------------------------------
	logic [7:0] rd_q;
	logic rd_thr_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= '0;
			rd_thr_q <= 1'b0;
		end else begin
			rd_thr_q <= bus_req.rd && (bus_req.addr >= csc_pkg::ADDR_THR_FIRST)
				&& (bus_req.addr <= csc_pkg::ADDR_THR_LAST);
			rd_q <= '0;
			if (bus_req.rd) begin
				case (bus_req.addr)
					csc_pkg::ADDR_MISC_MODE: rd_q <= {5'h0, misc_q};
					csc_pkg::ADDR_ROLE_8_11: rd_q <= role_q[23:16];
					csc_pkg::ADDR_ROLE_4_7: rd_q <= role_q[15:8];
					csc_pkg::ADDR_ROLE_0_3: rd_q <= role_q[7:0];
					csc_pkg::ADDR_RECAL: rd_q <= {4'h0, recal_code_q};
					csc_pkg::ADDR_PROX: rd_q <= prox_q;
					csc_pkg::ADDR_STATUS: begin
						rd_q[csc_pkg::STAT_INDIV_BIT] <= indiv_mode;
						rd_q[csc_pkg::STAT_CFG_ERR_BIT] <= config_error;
						rd_q[csc_pkg::STAT_SLIDER_BIT] <= slider_present;
						rd_q[csc_pkg::STAT_RECAL_WAIT_BIT] <= (rc_q == csc_pkg::CSC_RC_WAIT);
					end
					csc_pkg::ADDR_TOUCH_LO: rd_q <= touch_status[7:0];
					csc_pkg::ADDR_TOUCH_HI: rd_q <= {4'h0, touch_status[11:8]};
					csc_pkg::ADDR_SLIDER_SPAN: rd_q <= {slider_max_index, slider_min_index};
					default: begin
						if (bus_req.addr >= csc_pkg::ADDR_GAIN_FIRST
							&& bus_req.addr <= csc_pkg::ADDR_GAIN_LAST) begin
							rd_q <= gain_q[{gain_idx[2:0], 3'h0} +: 8];
						end
					end
				endcase
			end
		end
	end

	assign rd_data = rd_thr_q ? thr_a : rd_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_indiv_period: assert property (@(posedge mclk) disable iff (!reset_n)
		bus_req.wr && bus_req.addr == csc_pkg::ADDR_MISC_MODE && bus_req.wdata[2:0] == 3'h4
		|-> ##2 long_sense_period)
		else $error("individual mode did not lengthen sensing period");
	chk_common_level: assert property (@(posedge mclk) disable iff (!reset_n)
		sample.valid && !indiv_mode && !prox_on && gain_q[7:4] <= 4'h7
		|=> max_tick == 16'(16'd1000 * ({12'h0, $past(gain_q[7:4])} + 16'd1)))
		else $error("common level not applied");
	chk_tick_cap: assert property (@(posedge mclk) disable iff (!reset_n)
		scaled_valid |-> scaled_tick <= max_tick && max_tick <= 16'd32000)
		else $error("scaled tick above maximum");
	chk_touch_decide: assert property (@(posedge mclk) disable iff (!reset_n)
		scaled_valid && idx_ok_q |=> touch_status[$past(idx_q)] == $past(decide))
		else $error("touch decision not stored");
	chk_disabled_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
		##1 (touch_status & ~$past(active_mask)) == '0)
		else $error("inactive input reports touch");
	chk_recal_released: assert property (@(posedge mclk) disable iff (!reset_n)
		recal_pulse |-> $past(all_released) && $past(interval_s) != 6'h0)
		else $error("recalibration while touched or off");
	chk_slider_min: assert property (@(posedge mclk) disable iff (!reset_n)
		slider_present |-> slider_mask_q[slider_min_index]
		&& (slider_mask_q & ((12'h1 << slider_min_index) - 12'h1)) == '0)
		else $error("slider minimum not lowest member");
	chk_slider_max: assert property (@(posedge mclk) disable iff (!reset_n)
		slider_present |-> (slider_mask_q >> slider_max_index) == 12'h1)
		else $error("slider maximum not highest member");

endmodule

// ===== common/csc_pkg.sv
package csc_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int unsigned NUM_INPUTS = 12;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned RAW_W = 10;
	localparam int unsigned TICK_W = 16;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_MISC_MODE = 8'h09;
	localparam logic [7:0] ADDR_ROLE_8_11 = 8'h0a;
	localparam logic [7:0] ADDR_ROLE_4_7 = 8'h0b;
	localparam logic [7:0] ADDR_ROLE_0_3 = 8'h0c;
	localparam logic [7:0] ADDR_GAIN_FIRST = 8'h0d;
	localparam logic [7:0] ADDR_GAIN_LAST = 8'h12;
	localparam logic [7:0] ADDR_THR_FIRST = 8'h13;
	localparam logic [7:0] ADDR_THR_LAST = 8'h1e;
	localparam logic [7:0] ADDR_RECAL = 8'h1f;
	localparam logic [7:0] ADDR_PROX = 8'h70;
	localparam logic [7:0] ADDR_STATUS = 8'h71;
	localparam logic [7:0] ADDR_TOUCH_LO = 8'h72;
	localparam logic [7:0] ADDR_TOUCH_HI = 8'h73;
	localparam logic [7:0] ADDR_SLIDER_SPAN = 8'h74;

	// ---------------------------------------------------------------
	// Field values and reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] MODE_INDIVIDUAL = 3'h4;
	localparam logic [2:0] MISC_RST = 3'h0;
	localparam logic [7:0] ROLE_RST_8_11 = 8'haa;
	localparam logic [7:0] ROLE_RST_4_7 = 8'ha5;
	localparam logic [7:0] ROLE_RST_0_3 = 8'h55;
	localparam logic [7:0] GAIN_RST = 8'h00;
	localparam logic [3:0] GAIN_MAX = 4'h7;
	localparam logic [7:0] THR_RST = 8'ha0;
	localparam logic [3:0] RECAL_RST = 4'h0;
	localparam logic [7:0] PROX_OFF = 8'h46;
	localparam logic [7:0] PROX_ON = 8'h74;
	localparam logic [7:0] PROX_RST = PROX_OFF;
	localparam int unsigned STAT_INDIV_BIT = 0;
	localparam int unsigned STAT_CFG_ERR_BIT = 1;
	localparam int unsigned STAT_SLIDER_BIT = 2;
	localparam int unsigned STAT_RECAL_WAIT_BIT = 3;

	// ---------------------------------------------------------------
	// Tick scaling and configuration limits
	// ---------------------------------------------------------------
	localparam logic [15:0] TICK_STEP_OFF = 16'h03e8;
	localparam logic [15:0] TICK_STEP_ON = 16'h0fa0;
	localparam logic [3:0] MAX_BUTTONS = 4'h8;
	localparam logic [3:0] MIN_SLIDER = 4'h4;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned RECAL_UNIT_S = 1;
	localparam int unsigned RECAL_UNIT_CYCLES = CLK_HZ * RECAL_UNIT_S;
	localparam logic [5:0] RECAL_LONG_BASE_S = 6'h10;
	localparam logic [5:0] RECAL_MAX_S = 6'h3c;
	localparam logic [3:0] RECAL_CODE_MAX = 4'hf;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CSC_ROLE_DISABLED = 2'h0,
		CSC_ROLE_BUTTON = 2'h1,
		CSC_ROLE_SLIDER = 2'h2
	} csc_role_t;

	typedef enum logic [2:0] {
		CSC_RC_OFF = 3'b001,
		CSC_RC_COUNT = 3'b010,
		CSC_RC_WAIT = 3'b100
	} csc_recal_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csc_bus_req_t;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] index;
		logic [RAW_W-1:0] raw;
	} csc_sample_t;

endpackage

// ===== hdl/csc_thresh_mem.sv
`timescale 1ns/10ps
module csc_thresh_mem #(
	parameter int unsigned DEPTH = 12,
	parameter int unsigned WIDTH = 8,
	parameter logic [7:0] RST_VALUE = csc_pkg::THR_RST
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [3:0] rd_addr_a,
	output logic [WIDTH-1:0] rd_data_a,
	input wire logic [3:0] rd_addr_b,
	output logic [WIDTH-1:0] rd_data_b
);

	if (DEPTH > 16 || DEPTH < 1 || WIDTH != 8) begin : g_check
		$error("csc_thresh_mem: unsupported depth or width");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= RST_VALUE;
			end
		end else if (wr_en && (32'(wr_addr) < DEPTH)) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_a <= '0;
			rd_data_b <= '0;
		end else begin
			rd_data_a <= (32'(rd_addr_a) < DEPTH) ? mem_q[rd_addr_a] : '0;
			rd_data_b <= (32'(rd_addr_b) < DEPTH) ? mem_q[rd_addr_b] : '0;
		end
	end

endmodule

// ===== verification/csc_front_model.sv
`timescale 1ns/10ps
module csc_front_model (
	input wire logic mclk,
	output csc_pkg::csc_sample_t sample
);
	// ---------------------------------------------------------------
	// Sense front end: one strobe per scan result
	// ---------------------------------------------------------------
	initial begin
		sample = '0;
	end

	// Lines left behind after the strobe carry the inverse, never a stale copy
	task automatic send(input logic [3:0] idx, input logic [9:0] raw);
		sample <= '{valid: 1'b1, index: idx, raw: raw};
		@(posedge mclk);
		sample <= '{valid: 1'b0, index: ~idx, raw: ~raw};
	endtask
endmodule

// ===== verification/csc_config_logic_tb.sv
`timescale 1ns/10ps
module csc_config_logic_tb;
	// ---------------------------------------------------------------
	// Harness
	// ---------------------------------------------------------------
	localparam int unsigned UNIT = 10;
	localparam logic [7:0] RA [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h13, 8'h1f, 8'h70, 8'h20};
	localparam logic [7:0] RV [9] = '{8'h00, 8'haa, 8'ha5, 8'h55, 8'h00, 8'ha0, 8'h00, 8'h46, 8'h00};
	localparam int RC [5] = '{1, 7, 8, 14, 15};
	localparam int RS [5] = '{1, 7, 16, 28, 60};
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	csc_pkg::csc_bus_req_t bus_req = '0;
	csc_pkg::csc_sample_t sample;
	logic [7:0] rd_data;
	logic scaled_valid;
	logic [15:0] scaled_tick;
	logic [15:0] max_tick;
	logic [11:0] touch_status;
	logic long_sense_period;
	logic slider_present;
	logic [3:0] slider_min_index;
	logic [3:0] slider_max_index;
	logic config_error;
	logic recal_pulse;
	int n_errors = 0;
	int comparisons = 0;
	time t_a;
	time t_b;

	always #10 mclk = ~mclk;

	csc_front_model u_csc_front_model (.mclk(mclk), .sample(sample));

	csc_config_logic #(.RECAL_UNIT_CYCLES(UNIT)) u_csc_config_logic (
		.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
		.sample(sample), .scaled_valid(scaled_valid), .scaled_tick(scaled_tick),
		.max_tick(max_tick), .touch_status(touch_status),
		.long_sense_period(long_sense_period), .slider_present(slider_present),
		.slider_min_index(slider_min_index), .slider_max_index(slider_max_index),
		.config_error(config_error), .recal_pulse(recal_pulse)
	);

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus_req <= '0;
		@(posedge mclk);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		bus_req <= '0;
		#1;
		check(what, {8'h00, exp}, {8'h00, rd_data});
		@(posedge mclk);
	endtask

	function automatic logic [15:0] emax(input int lv, input int p);
		return 16'((lv + 1) * (p != 0 ? 4000 : 1000));
	endfunction

	function automatic logic [15:0] etick(input int raw, input int lv, input int p);
		int t;
		t = raw * (lv + 1) * (p != 0 ? 4 : 1);
		return (t > int'(emax(lv, p))) ? emax(lv, p) : 16'(t);
	endfunction

	task automatic smp(input logic [3:0] idx, input logic [9:0] raw, input logic [15:0] tk,
			input logic [15:0] mx);
		u_csc_front_model.send(idx, raw);
		#1;
		check("scaled_valid", 16'h0001, {15'h0, scaled_valid});
		check("scaled_tick", tk, scaled_tick);
		check("max_tick", mx, max_tick);
		@(posedge mclk);
	endtask

	task automatic tch(input logic [11:0] exp);
		#1;
		check("touch_status", {4'h0, exp}, {4'h0, touch_status});
		@(posedge mclk);
	endtask

	task automatic cfg(input logic pres, input logic [3:0] mn, input logic [3:0] mx,
			input logic err);
		#1;
		check("slider_present", {15'h0, pres}, {15'h0, slider_present});
		check("slider_min_index", {12'h0, mn}, {12'h0, slider_min_index});
		check("slider_max_index", {12'h0, mx}, {12'h0, slider_max_index});
		check("config_error", {15'h0, err}, {15'h0, config_error});
		@(posedge mclk);
	endtask

	task automatic wait_pulse(output time t);
		for (int i = 0; i < 1000; i++) begin
			@(posedge mclk);
			#1;
			if (recal_pulse === 1'b1) begin
				t = $time;
				@(posedge mclk);
				return;
			end
		end
		n_errors++;
		$display("[ERR] recal_pulse expected 1 seen 0");
		complete_run();
	endtask

	task automatic quiet(input int n);
		int c;
		c = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			#1;
			if (recal_pulse !== 1'b0) c++;
		end
		check("recal pulses", 16'h0000, 16'(c));
		@(posedge mclk);
	endtask

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 9; i++) rd_chk("reset value", RA[i], RV[i]);
		cfg(1'b1, 4'h6, 4'hb, 1'b0);
		$display("test reset done");

		for (int p = 0; p < 2; p++) begin
			wr(8'h70, p != 0 ? 8'h74 : 8'h46);
			for (int lv = 0; lv < 8; lv++) begin
				wr(8'h0d, {lv[3:0], 4'h0});
				smp(4'h7, 10'd100, etick(100, lv, p), emax(lv, p));
			end
		end
		smp(4'h7, 10'h3ff, etick(1023, 7, 1), emax(7, 1));
		wr(8'h0d, 8'h90);
		rd_chk("gain readback", 8'h0d, 8'h90);
		smp(4'h7, 10'd100, etick(100, 7, 1), emax(7, 1));
		wr(8'h70, 8'h46);
		wr(8'h0d, 8'h3f);
		smp(4'h0, 10'h3ff, etick(1023, 3, 0), emax(3, 0));
		$display("test gain done");

		wr(8'h0d, 8'h25);
		wr(8'h09, 8'h04);
		#1;
		check("long_sense_period", 16'h0001, {15'h0, long_sense_period});
		@(posedge mclk);
		rd_chk("status", 8'h71, 8'h05);
		smp(4'h1, 10'd10, 16'd60, 16'd6000);
		smp(4'h0, 10'd10, 16'd30, 16'd3000);
		wr(8'h09, 8'h03);
		#1;
		check("long_sense_period", 16'h0000, {15'h0, long_sense_period});
		@(posedge mclk);
		smp(4'h1, 10'd10, 16'd30, 16'd3000);
		wr(8'h0d, 8'h00);
		$display("test individual done");

		smp(4'h7, 10'd0, 16'd0, 16'd1000);
		smp(4'h0, 10'd0, 16'd0, 16'd1000);
		wr(8'h15, 8'h19);
		rd_chk("threshold", 8'h15, 8'h19);
		smp(4'h2, 10'd100, 16'd100, 16'd1000);
		tch(12'h000);
		smp(4'h2, 10'd101, 16'd101, 16'd1000);
		tch(12'h004);
		rd_chk("touch low", 8'h72, 8'h04);
		rd_chk("touch high", 8'h73, 8'h00);
		smp(4'hc, 10'h3ff, 16'd1000, 16'd1000);
		tch(12'h004);
		$display("test threshold done");

		wr(8'h0a, 8'h02);
		wr(8'h0c, 8'h40);
		wr(8'h0b, 8'ha2);
		cfg(1'b1, 4'h4, 4'h8, 1'b0);
		check("touch_status", 16'h0000, {4'h0, touch_status});
		rd_chk("slider span", 8'h74, 8'h84);
		wr(8'h0b, 8'ha6);
		cfg(1'b1, 4'h4, 4'h8, 1'b1);
		wr(8'h0b, 8'h0a);
		cfg(1'b1, 4'h4, 4'h8, 1'b1);
		wr(8'h0a, 8'h00);
		wr(8'h0b, 8'h55);
		wr(8'h0c, 8'h55);
		cfg(1'b0, 4'h0, 4'h0, 1'b0);
		wr(8'h0a, 8'h55);
		#1;
		check("config_error", 16'h0001, {15'h0, config_error});
		@(posedge mclk);
		wr(8'h0a, 8'haa);
		wr(8'h0b, 8'ha5);
		cfg(1'b1, 4'h6, 4'hb, 1'b0);
		$display("test roles done");

		for (int i = 0; i < 5; i++) begin
			wr(8'h1f, RC[i][7:0]);
			wait_pulse(t_a);
			wait_pulse(t_b);
			check("recal period", 16'(RS[i] * UNIT), 16'((t_b - t_a) / 20));
		end
		smp(4'h0, 10'h3ff, 16'd1000, 16'd1000);
		tch(12'h001);
		wr(8'h1f, 8'h01);
		quiet(30);
		rd_chk("status", 8'h71, 8'h0c);
		smp(4'h0, 10'd0, 16'd0, 16'd1000);
		wait_pulse(t_a);
		check("touch_status", 16'h0000, {4'h0, touch_status});
		wr(8'h1f, 8'h00);
		quiet(40);
		$display("test recal done");
		complete_run();
	end
endmodule
